// ### hw/nvsc_host.sv
// Purpose: host controller driving a byte-wide nonvolatile sram over its pins
// Assumes: one 20 MHz clock, device pins sampled synchronously
// Notes:   software store/recall is six reads issued by the user in order
// Operation
// RL1: reads keep write and busy lines high
// RL2: writes keep busy line high
// RL3: device floats data if write precedes select
// RL4: address changes only while deselected
// RL5: device pulls busy low on power fail
// RL6: device releases busy when nothing written
// RL7: store finishes within 10 ms
// RL8: power-up recall finishes within 550 us
// RL9: running access gets 1 us before store
// RL10: one select fall per sequence step
// RL11: six ordered reads start software store/recall
// RL12: write enable high through the six reads
// RL13: hardware store request low at least 15 ns
// RL14: device answers busy within 300 ns
// RL15: inhibit lifts within 700 ns after busy
// RL16: device ignores accesses during store or recall
`include "nvsc_params.svh"
module nvsc_host (
    input  wire logic                    sys_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    clk_en_in,
    // user side
    input  wire logic                    req_valid_in,
    input  wire nvsc_pkg::nvsc_op_t      req_op_in,
    input  wire logic [`NVSC_ADDR_W-1:0] req_addr_in,
    input  wire logic [`NVSC_DATA_W-1:0] req_wdata_in,
    output logic                         req_ready_out,
    output logic                         rsp_valid_out,
    output logic [`NVSC_DATA_W-1:0]      rsp_rdata_out,
    output logic                         nv_busy_out,
    output logic                         busy_timeout_out,
    // device pins
    output logic                         chip_en_n_out,
    output logic                         out_en_n_out,
    output logic                         wr_en_n_out,
    output logic [`NVSC_ADDR_W-1:0]      addr_out,
    input  wire logic [`NVSC_DATA_W-1:0] data_in,
    output logic [`NVSC_DATA_W-1:0]      data_out,
    output logic                         data_oe_out,
    input  wire logic                    hw_store_busy_n_in,
    output logic                         hw_store_busy_n_out,
    output logic                         hw_store_busy_oe_out
);
    nvsc_pkg::nvsc_state_t  state_reg;
    logic                   tmr_load;
    logic [`NVSC_CNT_W-1:0] tmr_value;
    logic                   tmr_done;
    logic                   busy_seen;

    localparam logic [`NVSC_CNT_W-1:0] ACC_CYC    = `NVSC_CNT_W'(`NVSC_ACC_CYC);
    localparam logic [`NVSC_CNT_W-1:0] PULSE_CYC  = `NVSC_CNT_W'(`NVSC_HW_PULSE_CYC);
    localparam logic [`NVSC_CNT_W-1:0] WAIT_CYC   = `NVSC_CNT_W'(`NVSC_BUSY_WAIT_CYC);
    localparam logic [`NVSC_CNT_W-1:0] INHIB_CYC  = `NVSC_CNT_W'(`NVSC_INHIBIT_CYC);
    localparam logic [`NVSC_CNT_W-1:0] STORE_CYC  = `NVSC_CNT_W'(`NVSC_STORE_CYC);
    localparam logic [`NVSC_CNT_W-1:0] RECALL_CYC = `NVSC_CNT_W'(`NVSC_RECALL_CYC);

    // busy line is low when the device (or anyone) pulls it
    assign busy_seen = !hw_store_busy_n_in;

    nvsc_timer u_timer (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .clk_en_in  (clk_en_in),
        .load_in    (tmr_load),
        .value_in   (tmr_value),
        .done_out   (tmr_done)
    );

    // timer loads follow the state the machine is about to leave
    always_comb begin
        tmr_load  = 1'b0;
        tmr_value = ACC_CYC;
        case (state_reg)
            nvsc_pkg::NVSC_IDLE: begin
                if (busy_seen) begin
                    // RL16: wait out device work
                    tmr_load  = 1'b1;
                    tmr_value = STORE_CYC;
                end else if (req_valid_in) begin
                    tmr_load = 1'b1;
                    if (req_op_in == nvsc_pkg::NVSC_OP_HWST) begin
                        tmr_value = PULSE_CYC;
                    end else if (req_op_in == nvsc_pkg::NVSC_OP_WAIT) begin
                        tmr_value = RECALL_CYC;
                    end
                end
            end
            nvsc_pkg::NVSC_RD_SET, nvsc_pkg::NVSC_WR_SET: begin
                tmr_load = 1'b1;
            end
            nvsc_pkg::NVSC_HS_PULSE: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_value = WAIT_CYC;
                end
            end
            nvsc_pkg::NVSC_HS_WAIT: begin
                if (busy_seen || tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_value = STORE_CYC;
                end
            end
            nvsc_pkg::NVSC_NV_BUSY: begin
                if (!busy_seen && tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_value = INHIB_CYC;
                end
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    // main sequencing of accesses and store handshakes
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_reg <= nvsc_pkg::NVSC_IDLE;
        end else if (clk_en_in) begin
            case (state_reg)
                nvsc_pkg::NVSC_IDLE: begin
                    if (busy_seen) begin
                        state_reg <= nvsc_pkg::NVSC_NV_BUSY;
                    end else if (req_valid_in) begin
                        case (req_op_in)
                            nvsc_pkg::NVSC_OP_READ:  state_reg <= nvsc_pkg::NVSC_RD_SET;
                            nvsc_pkg::NVSC_OP_WRITE: state_reg <= nvsc_pkg::NVSC_WR_SET;
                            nvsc_pkg::NVSC_OP_HWST:  state_reg <= nvsc_pkg::NVSC_HS_PULSE;
                            default:                 state_reg <= nvsc_pkg::NVSC_NV_BUSY;
                        endcase
                    end
                end
                nvsc_pkg::NVSC_RD_SET:  state_reg <= nvsc_pkg::NVSC_RD_HOLD;
                nvsc_pkg::NVSC_WR_SET:  state_reg <= nvsc_pkg::NVSC_WR_HOLD;
                nvsc_pkg::NVSC_RD_HOLD, nvsc_pkg::NVSC_WR_HOLD: begin
                    if (tmr_done) begin
                        state_reg <= nvsc_pkg::NVSC_GAP;
                    end
                end
                nvsc_pkg::NVSC_GAP:     state_reg <= nvsc_pkg::NVSC_IDLE;
                nvsc_pkg::NVSC_HS_PULSE: begin
                    if (tmr_done) begin
                        state_reg <= nvsc_pkg::NVSC_HS_WAIT;
                    end
                end
                nvsc_pkg::NVSC_HS_WAIT: begin
                    if (busy_seen || tmr_done) begin
                        state_reg <= nvsc_pkg::NVSC_NV_BUSY;
                    end
                end
                nvsc_pkg::NVSC_NV_BUSY: begin
                    // RL7: store wait ends once the timer runs out and busy is released
                    if (!busy_seen && tmr_done) begin
                        state_reg <= nvsc_pkg::NVSC_RECOVER;
                    end
                end
                nvsc_pkg::NVSC_RECOVER: begin
                    // RL15: inhibit lift wait
                    if (tmr_done) begin
                        state_reg <= nvsc_pkg::NVSC_IDLE;
                    end
                end
                default: state_reg <= nvsc_pkg::NVSC_IDLE;
            endcase
        end
    end

    // pin drive: address and data move only while chip enable is high
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            chip_en_n_out <= 1'b1;
            out_en_n_out  <= 1'b1;
            wr_en_n_out   <= 1'b1;
            addr_out      <= '0;
            data_out      <= '0;
            data_oe_out   <= 1'b0;
        end else if (clk_en_in) begin
            case (state_reg)
                nvsc_pkg::NVSC_IDLE: begin
                    chip_en_n_out <= 1'b1;
                    out_en_n_out  <= 1'b1;
                    wr_en_n_out   <= 1'b1;
                    data_oe_out   <= 1'b0;
                    // RL4: address set while deselected
                    if (req_valid_in && !busy_seen) begin
                        addr_out <= req_addr_in;
                        data_out <= req_wdata_in;
                    end
                end
                nvsc_pkg::NVSC_RD_SET: begin
                    // RL11 RL12: sequence steps are plain reads
                    // RL1: read with write high
                    // RL10: one select fall per read
                    chip_en_n_out <= 1'b0;
                    out_en_n_out  <= 1'b0;
                    wr_en_n_out   <= 1'b1;
                end
                nvsc_pkg::NVSC_WR_SET: begin
                    // RL2: write with busy released
                    chip_en_n_out <= 1'b0;
                    wr_en_n_out   <= 1'b0;
                    data_oe_out   <= 1'b1;
                end
                nvsc_pkg::NVSC_RD_HOLD, nvsc_pkg::NVSC_WR_HOLD: begin
                    if (tmr_done) begin
                        // write ends on write enable, select drops a cycle later
                        wr_en_n_out  <= 1'b1;
                        out_en_n_out <= 1'b1;
                    end
                end
                default: begin
                    chip_en_n_out <= 1'b1;
                    out_en_n_out  <= 1'b1;
                    wr_en_n_out   <= 1'b1;
                    data_oe_out   <= 1'b0;
                end
            endcase
        end
    end

    // read data captured at the end of the access
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end else if (clk_en_in) begin
            rsp_valid_out <= 1'b0;
            if (state_reg == nvsc_pkg::NVSC_RD_HOLD && tmr_done) begin
                rsp_valid_out <= 1'b1;
                rsp_rdata_out <= data_in;
            end
        end
    end

    // store request pulse and busy-answer watchdog
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            hw_store_busy_n_out  <= 1'b1;
            hw_store_busy_oe_out <= 1'b0;
            busy_timeout_out     <= 1'b0;
        end else if (clk_en_in) begin
            // RL13: pulse for the least width
            hw_store_busy_oe_out <= (state_reg == nvsc_pkg::NVSC_IDLE) && !busy_seen &&
                                    req_valid_in && (req_op_in == nvsc_pkg::NVSC_OP_HWST) ||
                                    (state_reg == nvsc_pkg::NVSC_HS_PULSE) && !tmr_done;
            hw_store_busy_n_out  <= 1'b0;  // only ever drives low, released by enable
            // RL14: flag missing busy answer
            if (state_reg == nvsc_pkg::NVSC_HS_WAIT && tmr_done && !busy_seen) begin
                busy_timeout_out <= 1'b1;
            end else if (state_reg == nvsc_pkg::NVSC_IDLE && req_valid_in) begin
                busy_timeout_out <= 1'b0;
            end
        end
    end

    // ready on entry to idle from an access or recovery, or in idle with no request and busy line released
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            req_ready_out <= 1'b0;
            nv_busy_out   <= 1'b0;
        end else if (clk_en_in) begin
            req_ready_out <= (state_reg == nvsc_pkg::NVSC_GAP) ||
                             (state_reg == nvsc_pkg::NVSC_IDLE && !req_valid_in && !busy_seen) ||
                             (state_reg == nvsc_pkg::NVSC_RECOVER && tmr_done);
            nv_busy_out   <= (state_reg == nvsc_pkg::NVSC_NV_BUSY) ||
                             (state_reg == nvsc_pkg::NVSC_RECOVER);
        end
    end
endmodule : nvsc_host

// ### hw/nvsc_params.svh
// Purpose: timing counts and fixed values for the nonvolatile sram host controller
// Assumes: 20 MHz system clock, 50 ns period
// Notes:   times other than the access phase are kept in their own unit, cycle counts derive from them
`ifndef NVSC_PARAMS_SVH
`define NVSC_PARAMS_SVH

`define NVSC_CLK_MHZ          20
`define NVSC_ADDR_W           13
`define NVSC_DATA_W           8
// least hardware store pulse, ns; rounds up, at least one cycle
`define NVSC_HW_PULSE_NS      15
`define NVSC_HW_PULSE_CYC     (((`NVSC_HW_PULSE_NS * `NVSC_CLK_MHZ) + 999) / 1000 < 1 ? 1 : \
                               ((`NVSC_HW_PULSE_NS * `NVSC_CLK_MHZ) + 999) / 1000)
// longest wait for busy answer, ns; rounds down
`define NVSC_BUSY_WAIT_NS     300
`define NVSC_BUSY_WAIT_CYC    ((`NVSC_BUSY_WAIT_NS * `NVSC_CLK_MHZ) / 1000)
// inhibit lift after busy release, ns
`define NVSC_INHIBIT_NS       700
`define NVSC_INHIBIT_CYC      ((`NVSC_INHIBIT_NS * `NVSC_CLK_MHZ) / 1000)
// store duration, ms; recall duration, us
`define NVSC_STORE_MS         10
`define NVSC_STORE_CYC        (`NVSC_STORE_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_RECALL_US        550
`define NVSC_RECALL_CYC       (`NVSC_RECALL_US * `NVSC_CLK_MHZ)
// access phase length in cycles, covers the slowest grade read cycle
`define NVSC_ACC_CYC          2
`define NVSC_CNT_W            20
`define NVSC_SEQ_LEN          6

`endif

// ### hw/nvsc_pkg.sv
// Purpose: types for the nonvolatile sram host controller
// Assumes: constants come from nvsc_params.svh
// Notes:   state codes are written out
package nvsc_pkg;
    typedef enum logic [3:0] {
        NVSC_IDLE     = 4'h0,
        NVSC_RD_SET   = 4'h1,
        NVSC_RD_HOLD  = 4'h2,
        NVSC_WR_SET   = 4'h3,
        NVSC_WR_HOLD  = 4'h4,
        NVSC_GAP      = 4'h5,
        NVSC_HS_PULSE = 4'h6,
        NVSC_HS_WAIT  = 4'h7,
        NVSC_NV_BUSY  = 4'h8,
        NVSC_RECOVER  = 4'h9
    } nvsc_state_t;

    typedef enum logic [1:0] {
        NVSC_OP_READ  = 2'h0,
        NVSC_OP_WRITE = 2'h1,
        NVSC_OP_HWST  = 2'h2,
        NVSC_OP_WAIT  = 2'h3
    } nvsc_op_t;
endpackage : nvsc_pkg

// ### hw/nvsc_timer.sv
// Purpose: loadable down counter used for every wait of the controller
// Assumes: load wins over counting
// Notes:   done is high while the count is zero
`include "nvsc_params.svh"
module nvsc_timer (
    input  wire logic                   sys_clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   clk_en_in,
    input  wire logic                   load_in,
    input  wire logic [`NVSC_CNT_W-1:0] value_in,
    output logic                        done_out
);
    logic [`NVSC_CNT_W-1:0] count_reg;

    // count down to zero and rest there
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            count_reg <= '0;
        end else if (clk_en_in) begin
            if (load_in) begin
                count_reg <= value_in;
            end else if (count_reg != '0) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    assign done_out = (count_reg == '0);
endmodule : nvsc_timer

// ### tb/nvsc_dev_model.sv
// Purpose: behavioural nonvolatile sram seen from its pins
// Assumes: pins sampled on the bench clock
// Notes:   store length shortened, released data toggles each cycle
`include "nvsc_params.svh"
module nvsc_dev_model #(
    parameter int STORE_CYC = 400
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    ce_n_in,
    input  wire logic                    oe_n_in,
    input  wire logic                    we_n_in,
    input  wire logic [`NVSC_ADDR_W-1:0] addr_in,
    input  wire logic [`NVSC_DATA_W-1:0] wdata_in,
    input  wire logic                    wdata_oe_in,
    input  wire logic                    busy_n_in,
    input  wire logic                    mute_in,
    input  wire logic                    pfail_in,
    output logic [`NVSC_DATA_W-1:0]      rdata_out,
    output logic                         busy_pull_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`NVSC_DATA_W-1:0] mem [0:(1<<`NVSC_ADDR_W)-1];
    logic [`NVSC_DATA_W-1:0] last_q;
    logic                    ce_q, float_q, dirty_q;
    int                      cnt_q;
    // floats when write leads select or busy
    assign rdata_out = (!ce_n_in && !oe_n_in && we_n_in && !float_q && !busy_pull_out) ?
                       mem[addr_in] : ~last_q;
    always_ff @(posedge sys_clk_in) begin
        last_q <= rdata_out;
        ce_q   <= ce_n_in;
        if (ce_q && !ce_n_in) float_q <= !we_n_in;
        if (reset_in) begin
            busy_pull_out <= 1'b0;
            cnt_q         <= 0;
            dirty_q       <= 1'b0;
            float_q       <= 1'b0;
            last_q        <= 8'h00;
        end else if (busy_pull_out) begin
            cnt_q <= cnt_q - 1;
            if (cnt_q == 1) busy_pull_out <= 1'b0;
        end else if (pfail_in) begin
            busy_pull_out <= 1'b1;
            cnt_q         <= dirty_q ? STORE_CYC : 20; // 1 us alert if nothing to save
            dirty_q       <= 1'b0;
        end else if (!busy_n_in && !mute_in) begin
            busy_pull_out <= 1'b1;
            cnt_q         <= STORE_CYC;
            dirty_q       <= 1'b0;
        end else if (!ce_n_in && !we_n_in && wdata_oe_in) begin
            mem[addr_in] <= wdata_in;
            dirty_q      <= 1'b1;
        end
    end
endmodule : nvsc_dev_model

// ### tb/nvsc_host_asserts.sv
// Purpose: port checks for nvsc_host
// Assumes: one clock, sync active-high reset
// Notes:   bound to every nvsc_host instance
`include "nvsc_params.svh"
module nvsc_host_asserts (
    input wire logic                   sys_clk_in,
    input wire logic                   reset_in,
    input wire logic                   req_ready_out,
    input wire logic                   rsp_valid_out,
    input wire logic                   busy_timeout_out,
    input wire logic                   chip_en_n_out,
    input wire logic                   out_en_n_out,
    input wire logic                   wr_en_n_out,
    input wire logic [`NVSC_ADDR_W-1:0] addr_out,
    input wire logic                   data_oe_out,
    input wire logic                   hw_store_busy_n_in,
    input wire logic                   hw_store_busy_n_out,
    input wire logic                   hw_store_busy_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    property p_rd; !out_en_n_out && !chip_en_n_out |-> wr_en_n_out && !hw_store_busy_oe_out;
    endproperty
    a_rd: assert property (p_rd) else $error("write or store line low in read");
    property p_wr; !wr_en_n_out |-> !chip_en_n_out && data_oe_out && !hw_store_busy_oe_out;
    endproperty
    a_wr: assert property (p_wr) else $error("bad line state in write");
    property p_adr; $changed(addr_out) |-> chip_en_n_out || wr_en_n_out; endproperty
    a_adr: assert property (p_adr) else $error("address moved while selected");
    // the host must never fight the device on the data bus
    property p_drv; data_oe_out |-> out_en_n_out; endproperty
    a_drv: assert property (p_drv) else $error("data driven with output enabled");
    property p_hsp; hw_store_busy_oe_out |-> !hw_store_busy_n_out && chip_en_n_out; endproperty
    a_hsp: assert property (p_hsp) else $error("store request not low");
    property p_tmo; $fell(hw_store_busy_oe_out) ##1 hw_store_busy_n_in[*7] |-> ##[0:2] busy_timeout_out;
    endproperty
    a_tmo: assert property (p_tmo) else $error("missing busy answer not flagged");
    property p_inh; !hw_store_busy_n_in ##1 !hw_store_busy_n_in |-> !req_ready_out; endproperty
    a_inh: assert property (p_inh) else $error("ready while device busy");
    // answer lands with output enable just raised, select still low for one more cycle
    property p_rsp; rsp_valid_out |-> out_en_n_out && !chip_en_n_out &&
        !$past(out_en_n_out, 2) ##1 !rsp_valid_out;
    endproperty
    a_rsp: assert property (p_rsp) else $error("read answer out of place");
    property p_ce; $fell(chip_en_n_out) |=> !chip_en_n_out[*3] ##1 chip_en_n_out; endproperty
    a_ce: assert property (p_ce) else $error("select low not one access");
endmodule : nvsc_host_asserts
bind nvsc_host nvsc_host_asserts nvsc_host_asserts_inst (.sys_clk_in, .reset_in, .req_ready_out,
    .rsp_valid_out, .busy_timeout_out, .chip_en_n_out, .out_en_n_out, .wr_en_n_out, .addr_out,
    .data_oe_out, .hw_store_busy_n_in, .hw_store_busy_n_out, .hw_store_busy_oe_out);

// ### tb/nvsc_host_bench.sv
// Purpose: self-checking bench for nvsc_host against the device model
// Assumes: 20 MHz clock, stores cut short by reset
// Notes:   store floor is too long to run, so store tests end in reset
`include "nvsc_params.svh"
module nvsc_host_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    sys_clk_in, reset_in, req_valid_in, mute, pfail, rsp_valid_out;
    logic                    req_ready_out, nv_busy_out, busy_timeout_out, ce_n, oe_n, we_n;
    logic                    data_oe, hsb_out, hsb_oe, pull, ce_q, clk_en;
    logic [`NVSC_ADDR_W-1:0] req_addr_in, addr_out;
    logic [`NVSC_DATA_W-1:0] req_wdata_in, rsp_rdata_out, data_in, data_out, v;
    nvsc_pkg::nvsc_op_t      req_op_in;
    int                      n_errors, n_tests, cyc, n_fall, k;
    wire                     busy_n = !(hsb_oe || pull); // pulled up, either side pulls low
    nvsc_host nvsc_host_inst (.sys_clk_in, .reset_in, .clk_en_in(clk_en), .req_valid_in, .req_op_in,
        .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .nv_busy_out,
        .busy_timeout_out, .chip_en_n_out(ce_n), .out_en_n_out(oe_n), .wr_en_n_out(we_n),
        .addr_out, .data_in, .data_out, .data_oe_out(data_oe), .hw_store_busy_n_in(busy_n),
        .hw_store_busy_n_out(hsb_out), .hw_store_busy_oe_out(hsb_oe));
    nvsc_dev_model nvsc_dev_model_inst (.sys_clk_in, .reset_in, .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .addr_in(addr_out), .wdata_in(data_out), .wdata_oe_in(data_oe),
        .busy_n_in(busy_n), .mute_in(mute), .pfail_in(pfail), .rdata_out(data_in),
        .busy_pull_out(pull));
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    // select falls and a hang limit well above the recall wait
    always @(posedge sys_clk_in) begin
        ce_q <= ce_n;
        if (ce_q === 1'b1 && ce_n === 1'b0) n_fall++;
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            $display("wrong value at %0t: %s", $time, m);
            n_errors++;
        end
    endtask : chk
    // valid is held until an edge sees ready with the line free
    task automatic issue(input nvsc_pkg::nvsc_op_t op, input logic [12:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        req_op_in <= op;
        req_addr_in <= a;
        req_wdata_in <= d;
        req_valid_in <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk_in); k++; end
        while (!(req_ready_out === 1'b1 && busy_n === 1'b1) && k < 20000);
        req_valid_in <= 1'b0;
    endtask : issue
    task automatic rd(input logic [12:0] a);
        issue(nvsc_pkg::NVSC_OP_READ, a, 8'h00);
        k = 0;
        do begin @(posedge sys_clk_in); k++; end while (rsp_valid_out !== 1'b1 && k < 10);
        v = rsp_rdata_out;
    endtask : rd
    task automatic t_wr_rd;
        issue(nvsc_pkg::NVSC_OP_WRITE, 13'h1fff, 8'ha5);
        issue(nvsc_pkg::NVSC_OP_WRITE, 13'h0000, 8'h5a);
        rd(13'h1fff);
        chk(v === 8'ha5, "top byte");
        rd(13'h0000);
        chk(v === 8'h5a, "bottom byte");
        $display("test wr_rd done");
    endtask : t_wr_rd
    task automatic t_sw_seq;
        int f0;
        f0 = n_fall;
        for (int i = 0; i < 6; i++) rd(13'h0aa0 + 13'(i));
        chk(n_fall - f0 == 6, "select falls per step");
        $display("test sw_seq done");
    endtask : t_sw_seq
    task automatic t_tmo;
        mute <= 1'b1;
        issue(nvsc_pkg::NVSC_OP_HWST, 13'h0000, 8'h00);
        repeat (12) @(posedge sys_clk_in);
        chk(busy_timeout_out === 1'b1, "silent device not flagged");
        mute <= 1'b0;
        // host now sits out the full store floor, too long to run, so cut it by reset
        reset_pulse();
        rd(13'h1fff);
        chk(busy_timeout_out === 1'b0 && v === 8'ha5, "flag or data after timeout");
        $display("test tmo done");
    endtask : t_tmo
    task automatic t_recall;
        issue(nvsc_pkg::NVSC_OP_WAIT, 13'h0000, 8'h00);
        repeat (2) @(posedge sys_clk_in);
        chk(nv_busy_out === 1'b1, "recall not busy");
        // a frozen stretch of 100 edges must push the end out to between 11090 and 11200 edges
        clk_en <= 1'b0;
        repeat (100) @(posedge sys_clk_in);
        clk_en <= 1'b1;
        k = 102;
        while (req_ready_out !== 1'b1 && k < 12200) begin @(posedge sys_clk_in); k++; end
        chk(k >= 11090 && k <= 11200, "recall wait length");
        $display("test recall done");
    endtask : t_recall
    task automatic reset_pulse;
        reset_in <= 1'b1;
        req_valid_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask : reset_pulse
    task automatic t_hw;
        issue(nvsc_pkg::NVSC_OP_HWST, 13'h0000, 8'h00);
        // let the edge pass: issue has just lowered valid in this time step
        @(posedge sys_clk_in);
        req_op_in <= nvsc_pkg::NVSC_OP_READ;
        req_valid_in <= 1'b1;
        repeat (30) @(posedge sys_clk_in);
        chk(busy_n === 1'b0 && nv_busy_out === 1'b1, "store not busy");
        chk(req_ready_out === 1'b0 && busy_timeout_out === 1'b0, "taken while busy");
        reset_pulse();
        $display("test hw done");
    endtask : t_hw
    task automatic t_pfail;
        pfail <= 1'b1;
        @(posedge sys_clk_in);
        pfail <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
        chk(busy_n === 1'b0 && nv_busy_out === 1'b1, "fail alert missed");
        repeat (20) @(posedge sys_clk_in);
        chk(busy_n === 1'b1 && req_ready_out === 1'b0, "idle alert");
        reset_pulse();
        issue(nvsc_pkg::NVSC_OP_WRITE, 13'h0010, 8'h3c);
        repeat (8) @(posedge sys_clk_in);
        pfail <= 1'b1;
        @(posedge sys_clk_in);
        pfail <= 1'b0;
        repeat (30) @(posedge sys_clk_in);
        chk(busy_n === 1'b0 && nv_busy_out === 1'b1, "dirty store released");
        reset_pulse();
        $display("test pfail done");
    endtask : t_pfail
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial begin
        {reset_in, req_valid_in, mute, pfail} = 4'h8;
        clk_en = 1'b1;
        {req_addr_in, req_wdata_in, n_errors, n_tests, cyc, n_fall} = '0;
        req_op_in = nvsc_pkg::NVSC_OP_READ;
        repeat (12) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        t_wr_rd();
        t_sw_seq();
        t_tmo();
        t_recall();
        t_hw();
        t_pfail();
        close_out();
    end
endmodule : nvsc_host_bench
